// *** dv/test_wiper_cascade_control.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Host and bank joined, driven from software.
// ----------------------------------------
module test_wiper_cascade_control;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [wcc_pkg::NPOT-1:0][5:0] wiper_tap;
  logic [3:0] wiper_off;
  logic [3:0] chain_up;
  int err_total = 0;
  int checks = 0;
  integer seed = 41562;
  logic rd_d = 1'b0;
  logic [7:0] expq[$]; // Expected read bytes, oldest first.
  logic [7:0] d;
  always #5 mclk = ~mclk;
  wcc_if link (.mclk(mclk), .arst_n(arst_n));
  wcc_dev #(.TWR_CYC(30)) wcc_dev_i (.link(link.dev), .wiper_tap(wiper_tap), .wiper_off(wiper_off),
    .chain_up(chain_up));
  wcc_host #(.PUR_CYC(20), .PUW_CYC(50), .TWR_CYC(30)) wcc_host_i (.mclk(mclk), .arst_n(arst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link.host));
  wcc_asserts #(.TWR_CYC(30)) wcc_asserts_i (.mclk(link.mclk), .arst_n(link.arst_n),
    .cmd_valid(link.cmd_valid), .cmd_op(link.cmd_op), .cmd_pot(link.cmd_pot), .cmd_reg(link.cmd_reg),
    .cmd_data(link.cmd_data), .cmd_ready(link.cmd_ready), .rsp_valid(link.rsp_valid),
    .rsp_data(link.rsp_data), .nv_busy(link.nv_busy));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    expq.push_back(exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  // Polls on the falling edge so the handshake is never sampled mid-update.
  task automatic cmd(input logic [3:0] op, input logic [1:0] p, input logic [1:0] r, input logic [7:0] v);
    int n;
    wr_reg(wcc_pkg::ADDR_DATA, v);
    wr_reg(wcc_pkg::ADDR_CMD, {r, p, op});
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (!(link.cmd_valid === 1'b1 && link.cmd_ready === 1'b1) && n < 300);
    if (n >= 300)
      chk(8'h01, 8'h00);
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic rdw(input logic [3:0] op, input logic [1:0] p, input logic [1:0] r, input logic [7:0] e);
    cmd(op, p, r, 8'h00);
    rd_reg(wcc_pkg::ADDR_RSP, e);
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Read data stand one cycle after the strobe; pair them with the oldest note.
  always @(posedge mclk)
  begin
    rd_d <= rd;
    if (rd_d && expq.size() > 0)
      chk(rdata, expq.pop_front());
  end
  // Cuts a hang short; the whole sequence needs a few hundred cycles.
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end
  // Main sequence: load, random writes, chain hops, copies and a save.
  initial
  begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    // Straight after reset only the store timer shows expired.
    rd_reg(wcc_pkg::ADDR_STAT, 8'h08);
    for (int p = 0; p < 4; p++)
      rdw(wcc_pkg::OP_READ_WIPER, 2'(p), 2'd0, wcc_pkg::DR_RESET);
    for (int p = 0; p < 4; p++)
    begin
      d = {1'b0, 7'($random(seed))};
      cmd(wcc_pkg::OP_WRITE_WIPER, 2'(p), 2'd0, d);
      chk({2'b00, wiper_tap[p]}, {2'b00, d[5:0]});
      chk({6'h00, chain_up[p], wiper_off[p]}, {6'h00, d[7:6]});
      rdw(wcc_pkg::OP_READ_WIPER, 2'(p), 2'd0, d);
    end
    // Pot 1 chained at its top tap, pot 2 floating: one live wiper.
    cmd(wcc_pkg::OP_WRITE_WIPER, 2'd1, 2'd0, 8'hBF);
    cmd(wcc_pkg::OP_WRITE_WIPER, 2'd2, 2'd0, 8'h40);
    cmd(wcc_pkg::OP_STEP_SEL, 2'd1, 2'd0, 8'h00);
    cmd(wcc_pkg::OP_STEP, 2'd1, 2'd0, 8'h01);
    chk({1'b0, wiper_off[2], wiper_tap[2]}, 8'h00);
    rdw(wcc_pkg::OP_READ_WIPER, 2'd1, 2'd0, 8'hFF);
    cmd(wcc_pkg::OP_STEP, 2'd1, 2'd0, 8'h00);
    chk({chain_up[1], wiper_off[1], wiper_tap[1]}, 8'hBF);
    chk({7'h00, wiper_off[2]}, 8'h01);
    cmd(wcc_pkg::OP_STEP, 2'd1, 2'd0, 8'h00);
    chk({chain_up[1], wiper_off[1], wiper_tap[1]}, 8'hBE);
    // A copy gives no answer, so the new byte is fetched by a read of its own.
    cmd(wcc_pkg::OP_COPY_TO_WIPER, 2'd3, 2'd0, 8'h00);
    chk({2'b00, wiper_tap[3]}, 8'h20);
    rdw(wcc_pkg::OP_READ_WIPER, 2'd3, 2'd0, wcc_pkg::DR_RESET);
    // Saving all wipers before power-off; the host holds off until the store settles.
    wr_reg(wcc_pkg::ADDR_SAVE, 8'h01);
    rdw(wcc_pkg::OP_READ_STORE, 2'd1, 2'd1, 8'hBE);
    // Store write, group copy back to the wipers, then a single save read back.
    cmd(wcc_pkg::OP_WRITE_STORE, 2'd0, 2'd2, 8'h5A);
    cmd(wcc_pkg::OP_GCOPY_TO_WIPER, 2'd0, 2'd2, 8'h00);
    chk({chain_up[0], wiper_off[0], wiper_tap[0]}, 8'h5A);
    chk({chain_up[2], wiper_off[2], wiper_tap[2]}, wcc_pkg::DR_RESET);
    cmd(wcc_pkg::OP_COPY_TO_STORE, 2'd0, 2'd3, 8'h00);
    rdw(wcc_pkg::OP_READ_STORE, 2'd0, 2'd3, 8'h5A);
    // All windows open and nothing pending once the last store has settled.
    rd_reg(wcc_pkg::ADDR_STAT, 8'h0E);
    rd_reg(wcc_pkg::ADDR_DATA, 8'h00);
    rd_reg(4'hF, 8'h00);
    repeat (5) @(posedge mclk);
    report_and_stop();
  end
endmodule

// *** dv/wcc_asserts.sv ***
`timescale 1ns/100ps
// ----------------------------------------
// Link checker for the pot register bank.
// ----------------------------------------
module wcc_asserts
#(
  parameter int TWR_CYC = 30
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire wcc_pkg::wcc_op_e cmd_op,
  input wire logic [1:0] cmd_pot,
  input wire logic [1:0] cmd_reg,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic nv_busy
);
  // Longest busy span allowed, with slack for the handshake.
  localparam int BUSY_MAX = TWR_CYC + 2;
  // A command counts only on an edge where both halves agree.
  wire take = cmd_valid && cmd_ready;
  wire rd_op = (cmd_op == wcc_pkg::OP_READ_WIPER) || (cmd_op == wcc_pkg::OP_READ_STORE);
  wire st_op = (cmd_op == wcc_pkg::OP_WRITE_STORE) || (cmd_op == wcc_pkg::OP_COPY_TO_STORE)
    || (cmd_op == wcc_pkg::OP_GCOPY_TO_STORE);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);
  property p_rsp_after_read;
    take && rd_op |=> rsp_valid;
  endproperty
  a_rsp_after_read: assert property (p_rsp_after_read) else $error("read answer missing");
  property p_rsp_cause;
    rsp_valid |-> $past(take && rd_op);
  endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer without a read");
  property p_no_rsp_write;
    take && !rd_op |=> !rsp_valid;
  endproperty
  a_no_rsp_write: assert property (p_no_rsp_write) else $error("answer after a write");
  property p_rsp_hold;
    !rsp_valid |-> $stable(rsp_data);
  endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("answer byte moved");
  property p_busy_start;
    take && st_op |=> nv_busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("store busy missing");
  property p_busy_refuse;
    nv_busy |-> !cmd_ready;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("ready while busy");
  property p_busy_min;
    $rose(nv_busy) |-> nv_busy[*8];
  endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_end;
    $rose(nv_busy) |-> ##[1:BUSY_MAX] !nv_busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("busy too long");
  property p_ready_late;
    !$past(arst_n) |-> !cmd_ready;
  endproperty
  a_ready_late: assert property (p_ready_late) else $error("ready during load");
  // Main traffic kinds seen on the link.
  c_read: cover property (take && rd_op);
  c_store: cover property ($rose(nv_busy));
  c_step: cover property (take && cmd_op == wcc_pkg::OP_STEP);
endmodule

// *** rtl/wcc_dev.sv ***
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Pot register bank: four wiper bytes and sixteen stored settings.
// ----------------------------------------------------------------------------
module wcc_dev
#(
  parameter int TWR_CYC = wcc_pkg::TWR_CYC
)
(
  wcc_if.dev link,
  output logic [wcc_pkg::NPOT-1:0][5:0] wiper_tap,
  output logic [wcc_pkg::NPOT-1:0] wiper_off,
  output logic [wcc_pkg::NPOT-1:0] chain_up
);
  localparam int NPOT = wcc_pkg::NPOT;
  localparam int NDR = wcc_pkg::NPOT * wcc_pkg::NREG;
  localparam int PM = wcc_pkg::POS_MSB;
  localparam int OB = wcc_pkg::OFF_BIT;
  localparam int CB = wcc_pkg::CHAIN_BIT;
  localparam logic [wcc_pkg::TMR_W-1:0] TWR_LIM = wcc_pkg::TMR_W'(TWR_CYC);

  // ---------------------------------------------------------------------------
  // Helpers.
  // ---------------------------------------------------------------------------
  // Flat index of a stored setting from pot and register number.
  function automatic logic [3:0] dr_idx(input logic [1:0] pot, input logic [1:0] rg);
    dr_idx = {pot, rg};
  endfunction

  // Byte with only the position field replaced.
  function automatic logic [7:0] set_pos(input logic [7:0] w, input logic [5:0] pos);
    set_pos = {w[CB:OB], pos};
  endfunction

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  logic [7:0] wcr_q [NPOT];   // Volatile wiper bytes.
  logic [7:0] wcr_d [NPOT];
  logic [7:0] dr_q [NDR];     // Stored settings, modelled as registers.
  logic [1:0] step_pot_q;     // Pot that step pulses act on.
  logic [1:0] step_pot_d;
  logic pwrup_q;              // High for the first cycle after reset.
  logic cmd_ready_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic nv_busy_q;
  logic nv_done;              // Store timer has expired.

  // ---------------------------------------------------------------------------
  // Command decode.
  // ---------------------------------------------------------------------------
  // Clock and reset come from the link, so both ends share one domain.
  wire mclk_w = link.mclk;
  wire rst_w = link.arst_n;
  wire take = link.cmd_valid & cmd_ready_q;
  wire op_rd_w = (link.cmd_op == wcc_pkg::OP_READ_WIPER);
  wire op_rd_s = (link.cmd_op == wcc_pkg::OP_READ_STORE);
  wire op_wr_s = (link.cmd_op == wcc_pkg::OP_WRITE_STORE);
  wire op_cp_s = (link.cmd_op == wcc_pkg::OP_COPY_TO_STORE);
  wire op_gcp_s = (link.cmd_op == wcc_pkg::OP_GCOPY_TO_STORE);
  // Any store change starts the write-cycle timer.
  wire nv_start = take & (op_wr_s | op_cp_s | op_gcp_s);
  wire [3:0] sel_idx = dr_idx(link.cmd_pot, link.cmd_reg);

  // ---------------------------------------------------------------------------
  // Step decode for the selected pot.
  // ---------------------------------------------------------------------------
  wire [1:0] sp_up = step_pot_q + 2'h1;
  wire [1:0] sp_dn = step_pot_q - 2'h1;
  wire [7:0] cur_w = wcr_q[step_pot_q];
  wire [5:0] cur_pos = cur_w[PM:0];
  wire dir_up = link.cmd_data[0];
  // A pot joins upward only if its chain bit is set and a higher pot exists.
  wire link_up = cur_w[CB] & (step_pot_q != 2'(NPOT - 1));
  wire link_dn = (step_pot_q != 2'h0) & wcr_q[sp_dn][CB];
  wire hop_up = dir_up & (cur_pos == wcc_pkg::TAP_MAX) & link_up;
  wire hop_dn = !dir_up & (cur_pos == wcc_pkg::TAP_MIN) & link_dn;
  wire can_inc = dir_up & (cur_pos != wcc_pkg::TAP_MAX);
  wire can_dec = !dir_up & (cur_pos != wcc_pkg::TAP_MIN);

  // ---------------------------------------------------------------------------
  // Next wiper bytes. Power-up load wins over any command.
  // ---------------------------------------------------------------------------
  always_comb
  begin
    for (int p = 0; p < NPOT; p++)
    begin
      wcr_d[p] = wcr_q[p];
    end
    step_pot_d = step_pot_q;
    if (pwrup_q)
    begin
      // Each wiper restarts from its first stored setting.
      for (int p = 0; p < NPOT; p++)
      begin
        wcr_d[p] = dr_q[dr_idx(2'(p), 2'h0)];
      end
    end
    else if (take)
    begin
      case (link.cmd_op)
        wcc_pkg::OP_WRITE_WIPER:
        begin
          // Whole byte: position plus off and chain bits.
          wcr_d[link.cmd_pot] = link.cmd_data;
        end
        wcc_pkg::OP_COPY_TO_WIPER:
        begin
          wcr_d[link.cmd_pot] = dr_q[sel_idx];
        end
        wcc_pkg::OP_GCOPY_TO_WIPER:
        begin
          for (int p = 0; p < NPOT; p++)
          begin
            wcr_d[p] = dr_q[dr_idx(2'(p), link.cmd_reg)];
          end
        end
        wcc_pkg::OP_STEP_SEL:
        begin
          step_pot_d = link.cmd_pot;
        end
        wcc_pkg::OP_STEP:
        begin
          if (hop_up)
          begin
            // Leave this array at its top; the next one takes over at tap 0.
            wcr_d[step_pot_q][OB] = 1'b1;
            wcr_d[sp_up] = set_pos(wcr_q[sp_up], wcc_pkg::TAP_MIN);
            wcr_d[sp_up][OB] = 1'b0;
            step_pot_d = sp_up;
          end
          else if (hop_dn)
          begin
            // Leave this array at its bottom; the lower one resumes at its top.
            wcr_d[step_pot_q][OB] = 1'b1;
            wcr_d[sp_dn] = set_pos(wcr_q[sp_dn], wcc_pkg::TAP_MAX);
            wcr_d[sp_dn][OB] = 1'b0;
            step_pot_d = sp_dn;
          end
          else if (can_inc)
          begin
            wcr_d[step_pot_q] = set_pos(cur_w, cur_pos + 6'h01);
          end
          else if (can_dec)
          begin
            wcr_d[step_pot_q] = set_pos(cur_w, cur_pos - 6'h01);
          end
          else
          begin
            // An unchained end simply holds.
            wcr_d[step_pot_q] = cur_w;
          end
        end
        default:
        begin
          // Reads and store updates leave the wipers alone.
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Wiper bytes, step pointer and power-up marker.
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_w or negedge rst_w)
  begin
    if (!rst_w)
    begin
      for (int p = 0; p < NPOT; p++)
      begin
        wcr_q[p] <= 8'h00;
      end
      step_pot_q <= 2'h0;
      pwrup_q <= 1'b1;
    end
    else
    begin
      wcr_q <= wcr_d;
      step_pot_q <= step_pot_d;
      pwrup_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Stored settings. Only taken commands reach here, so a store change is
  // never started while an earlier one is still completing.
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_w or negedge rst_w)
  begin
    if (!rst_w)
    begin
      for (int i = 0; i < NDR; i++)
      begin
        dr_q[i] <= wcc_pkg::DR_RESET;
      end
    end
    else if (take & op_wr_s)
    begin
      dr_q[sel_idx] <= link.cmd_data;
    end
    else if (take & op_cp_s)
    begin
      dr_q[sel_idx] <= wcr_q[link.cmd_pot];
    end
    else if (take & op_gcp_s)
    begin
      // All pots save together, so a chained position survives power loss.
      for (int p = 0; p < NPOT; p++)
      begin
        dr_q[dr_idx(2'(p), link.cmd_reg)] <= wcr_q[p];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Write-cycle timer; starts expired so the bank is usable after reset.
  // ---------------------------------------------------------------------------
  wcc_timer #(
    .W(wcc_pkg::TMR_W),
    .LIMIT(TWR_LIM),
    .START_DONE(1'b1)
  ) u_twr (
    .mclk(mclk_w),
    .arst_n(rst_w),
    .clear(nv_start),
    .count(),
    .done(nv_done)
  );

  // ---------------------------------------------------------------------------
  // Link answers. Read data leaves one cycle after the command is taken.
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk_w or negedge rst_w)
  begin
    if (!rst_w)
    begin
      cmd_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
      nv_busy_q <= 1'b0;
    end
    else
    begin
      // Refuse everything during power-up load and a store write cycle.
      cmd_ready_q <= !pwrup_q & !nv_start & nv_done;
      nv_busy_q <= nv_start | !nv_done;
      rsp_valid_q <= take & (op_rd_w | op_rd_s);
      if (take & op_rd_w)
      begin
        // Full byte, so the off bit tells which chained array is live.
        rsp_data_q <= wcr_q[link.cmd_pot];
      end
      else if (take & op_rd_s)
      begin
        rsp_data_q <= dr_q[sel_idx];
      end
    end
  end

  assign link.cmd_ready = cmd_ready_q;
  assign link.rsp_valid = rsp_valid_q;
  assign link.rsp_data = rsp_data_q;
  assign link.nv_busy = nv_busy_q;

  // ---------------------------------------------------------------------------
  // Analog-side controls straight from the wiper bytes.
  // ---------------------------------------------------------------------------
  always_comb
  begin
    for (int p = 0; p < NPOT; p++)
    begin
      wiper_tap[p] = wcr_q[p][PM:0];
      // High leaves the wiper terminal isolated and floating.
      wiper_off[p] = wcr_q[p][OB];
      chain_up[p] = wcr_q[p][CB];
    end
  end
endmodule

// *** rtl/wcc_host.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Host sequencer: software orders commands through a small register port.
// ----------------------------------------------------------------------------
module wcc_host
#(
  parameter int PUR_CYC = wcc_pkg::PUR_CYC,
  parameter int PUW_CYC = wcc_pkg::PUW_CYC,
  parameter int TWR_CYC = wcc_pkg::TWR_CYC
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  wcc_if.host link
);
  localparam int TW = wcc_pkg::TMR_W;

  // ---------------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------------
  wcc_pkg::wcc_hst_e st_q;
  wcc_pkg::wcc_hst_e st_d;
  logic pend_q;               // A command waits to go out.
  wcc_pkg::wcc_op_e op_q;
  logic [1:0] pot_q;
  logic [1:0] reg_q;
  logic [7:0] data_q;
  logic [7:0] rsp_q;          // Last read answer.
  logic [7:0] rdata_q;
  logic cmd_valid_q;
  logic [TW-1:0] pwr_cnt;
  logic write_ok;
  logic nv_ok;

  // ---------------------------------------------------------------------------
  // Decode.
  // ---------------------------------------------------------------------------
  wire wr_cmd = wr & (addr == wcc_pkg::ADDR_CMD);
  wire wr_data = wr & (addr == wcc_pkg::ADDR_DATA);
  wire wr_save = wr & (addr == wcc_pkg::ADDR_SAVE);
  wire is_read = (op_q == wcc_pkg::OP_READ_WIPER) | (op_q == wcc_pkg::OP_READ_STORE);
  wire is_nv = (op_q == wcc_pkg::OP_WRITE_STORE) | (op_q == wcc_pkg::OP_COPY_TO_STORE) |
               (op_q == wcc_pkg::OP_GCOPY_TO_STORE);
  wire read_ok = (pwr_cnt >= TW'(PUR_CYC));
  // Power-up window per kind, and no order while a store update runs.
  wire may_go = (is_read ? read_ok : write_ok) & nv_ok & !link.nv_busy;
  wire taken = cmd_valid_q & link.cmd_ready;
  wire [7:0] stat = {4'h0, nv_ok, write_ok, read_ok, pend_q | (st_q != wcc_pkg::ST_IDLE)};
  wire [7:0] rd_mux = (addr == wcc_pkg::ADDR_STAT) ? stat :
                      (addr == wcc_pkg::ADDR_RSP) ? rsp_q :
                      (addr == wcc_pkg::ADDR_DATA) ? data_q : 8'h00;

  // ---------------------------------------------------------------------------
  // Power-up and write-cycle timers.
  // ---------------------------------------------------------------------------
  wcc_timer #(
    .W(TW),
    .LIMIT(TW'(PUW_CYC)),
    .START_DONE(1'b0)
  ) u_pwr (
    .mclk(mclk),
    .arst_n(arst_n),
    .clear(1'b0),
    .count(pwr_cnt),
    .done(write_ok)
  );

  wcc_timer #(
    .W(TW),
    .LIMIT(TW'(TWR_CYC)),
    .START_DONE(1'b1)
  ) u_nv (
    .mclk(mclk),
    .arst_n(arst_n),
    .clear(taken & is_nv),
    .count(),
    .done(nv_ok)
  );

  // ---------------------------------------------------------------------------
  // Sequencer next state.
  // ---------------------------------------------------------------------------
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      wcc_pkg::ST_IDLE:
      begin
        if (pend_q & may_go)
        begin
          st_d = wcc_pkg::ST_ISSUE;
        end
      end
      wcc_pkg::ST_ISSUE:
      begin
        if (taken)
        begin
          st_d = is_read ? wcc_pkg::ST_WAIT : wcc_pkg::ST_IDLE;
        end
      end
      wcc_pkg::ST_WAIT:
      begin
        if (link.rsp_valid)
        begin
          st_d = wcc_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_d = wcc_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // Registers. A new order while one is pending overwrites it; software
  // should poll the busy bit first.
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= wcc_pkg::ST_IDLE;
      pend_q <= 1'b0;
      op_q <= wcc_pkg::OP_READ_WIPER;
      pot_q <= 2'h0;
      reg_q <= 2'h0;
      data_q <= 8'h00;
      rsp_q <= 8'h00;
      rdata_q <= 8'h00;
      cmd_valid_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      rdata_q <= rd ? rd_mux : rdata_q;
      cmd_valid_q <= (st_d == wcc_pkg::ST_ISSUE);
      if (wr_cmd)
      begin
        // Data byte is sent as written: the one-live-wiper duty is software's.
        pend_q <= 1'b1;
        op_q <= wcc_pkg::wcc_op_e'(wdata[3:0]);
        pot_q <= wdata[5:4];
        reg_q <= wdata[7:6];
      end
      else if (wr_save)
      begin
        // Save all wipers into one stored setting before power is removed.
        pend_q <= 1'b1;
        op_q <= wcc_pkg::OP_GCOPY_TO_STORE;
        reg_q <= wdata[1:0];
      end
      else if (taken)
      begin
        pend_q <= 1'b0;
      end
      if (wr_data)
      begin
        data_q <= wdata;
      end
      if (link.rsp_valid)
      begin
        rsp_q <= link.rsp_data;
      end
    end
  end

  assign rdata = rdata_q;
  assign link.cmd_valid = cmd_valid_q;
  assign link.cmd_op = op_q;
  assign link.cmd_pot = pot_q;
  assign link.cmd_reg = reg_q;
  assign link.cmd_data = data_q;
endmodule

// *** rtl/wcc_if.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Command link between the host sequencer and the pot register bank.
// ----------------------------------------------------------------------------
interface wcc_if
(
  input wire logic mclk,
  input wire logic arst_n
);
  logic cmd_valid;          // Host offers a command.
  wcc_pkg::wcc_op_e cmd_op; // Instruction code.
  logic [1:0] cmd_pot;      // Pot select.
  logic [1:0] cmd_reg;      // Stored setting select.
  logic [7:0] cmd_data;     // Data byte; bit 0 is direction for a step.
  logic cmd_ready;          // Device accepts in this cycle.
  logic rsp_valid;          // Read answer, one cycle.
  logic [7:0] rsp_data;     // Read answer byte.
  logic nv_busy;            // Stored setting update in progress.

  modport dev
  (
    input mclk, arst_n, cmd_valid, cmd_op, cmd_pot, cmd_reg, cmd_data,
    output cmd_ready, rsp_valid, rsp_data, nv_busy
  );

  modport host
  (
    input mclk, arst_n, cmd_ready, rsp_valid, rsp_data, nv_busy,
    output cmd_valid, cmd_op, cmd_pot, cmd_reg, cmd_data
  );
endinterface

// *** rtl/wcc_pkg.sv ***
// ----------------------------------------------------------------------------
// Shared constants for the wiper cascade control ends.
// ----------------------------------------------------------------------------
package wcc_pkg;

  // Array geometry: pots, stored settings per pot and index widths.
  localparam int NPOT = 4;
  localparam int NREG = 4;
  localparam int PW = 2;
  localparam int RW = 2;

  // Wiper control byte layout: position in the low six bits.
  localparam int POS_MSB = 5;
  localparam int OFF_BIT = 6;
  localparam int CHAIN_BIT = 7;
  localparam logic [5:0] TAP_MAX = 6'h3F;
  localparam logic [5:0] TAP_MIN = 6'h00;

  // Value held by every stored setting after reset.
  localparam logic [7:0] DR_RESET = 8'h20;

  // Timing figures in milliseconds and the clock rate in cycles per ms.
  localparam int CYC_PER_MS = 100000;
  localparam int PUR_MS = 1;
  localparam int PUW_MS = 5;
  localparam int TWR_MS = 10;
  localparam int PUR_CYC = PUR_MS * CYC_PER_MS;
  localparam int PUW_CYC = PUW_MS * CYC_PER_MS;
  localparam int TWR_CYC = TWR_MS * CYC_PER_MS;
  localparam int TMR_W = 24;

  // Instruction codes on the link; OP_STEP is one step pulse.
  typedef enum logic [3:0] {
    OP_GCOPY_TO_WIPER = 4'h1,
    OP_STEP_SEL = 4'h2,
    OP_STEP = 4'h3,
    OP_GCOPY_TO_STORE = 4'h8,
    OP_READ_WIPER = 4'h9,
    OP_WRITE_WIPER = 4'hA,
    OP_READ_STORE = 4'hB,
    OP_WRITE_STORE = 4'hC,
    OP_COPY_TO_WIPER = 4'hD,
    OP_COPY_TO_STORE = 4'hE
  } wcc_op_e;

  // Host sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ISSUE = 3'b010,
    ST_WAIT = 3'b100
  } wcc_hst_e;

  // Host register offsets on the software port.
  localparam logic [3:0] ADDR_CMD = 4'h0;
  localparam logic [3:0] ADDR_DATA = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_RSP = 4'h3;
  localparam logic [3:0] ADDR_SAVE = 4'h4;

endpackage

// *** rtl/wcc_timer.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Saturating elapsed-time counter with a registered done flag.
// ----------------------------------------------------------------------------
module wcc_timer
#(
  parameter int W = 24,
  parameter logic [W-1:0] LIMIT = '1,
  parameter bit START_DONE = 1'b0
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clear,
  output logic [W-1:0] count,
  output logic done
);
  // Start either expired, so a bank is usable at once, or from zero.
  localparam logic [W-1:0] CNT_RESET = START_DONE ? LIMIT : '0;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic done_q;

  // Counting stops at the limit so the flag never wraps back low.
  assign cnt_d = clear ? '0 : ((cnt_q == LIMIT) ? cnt_q : cnt_q + 1'b1);

  // ---------------------------------------------------------------------------
  // Counter and flag.
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_q <= CNT_RESET;
      done_q <= START_DONE;
    end
    else
    begin
      cnt_q <= cnt_d;
      done_q <= (cnt_d == LIMIT);
    end
  end

  assign count = cnt_q;
  assign done = done_q;
endmodule
